// ### hdl/ple_pkg.sv
// package of constants for the port link event state machine
package ple_pkg;
   // ****************************************
   // register map (word aligned byte offsets)
   // ****************************************
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STAT_OFS   = 8'h04;
   localparam logic [7:0] TFD_OFS    = 8'h08;
   localparam logic [7:0] SIG_OFS    = 8'h0c;
   localparam logic [7:0] CI_OFS     = 8'h10;
   localparam logic [7:0] SACT_OFS   = 8'h14;
   localparam logic [7:0] DIAG_OFS   = 8'h18;
   // ctrl fields
   localparam int CTRL_ST_BIT   = 0;
   localparam int CTRL_FRE_BIT  = 1;
   localparam int CTRL_PCE_BIT  = 2;
   localparam int CTRL_GIE_BIT  = 3;
   localparam int CTRL_HINIT_BIT = 4;
   localparam int CTRL_CR_BIT   = 15;
   localparam int CTRL_CCS_LSB  = 8;
   // stat fields
   localparam int STAT_DET_LSB  = 0;
   localparam int STAT_IPS_BIT  = 4;
   localparam int STAT_IRQ_BIT  = 5;
   localparam int STAT_UPD_BIT  = 6;
   localparam int STAT_PROC_BIT = 7;
   localparam int STAT_OFFL_BIT = 8;
   localparam int STAT_STATE_LSB = 12;
   // task file status bits
   localparam int TFS_BSY_BIT   = 7;
   localparam int TFS_DRQ_BIT   = 3;
   // reset and load values
   localparam logic [7:0] TFS_INIT_VAL   = 8'h7f;
   localparam logic [7:0] TFS_COMINIT_FF = 8'hff;
   localparam logic [7:0] TFS_COMINIT_80 = 8'h80;
   localparam logic [3:0] DET_PRESENT    = 4'h1;
   // received frame layout: word0 = {err, status, flags, type}
   localparam int FRM_STS_LSB  = 16;
   localparam int FRM_ERR_LSB  = 24;
   localparam int FRM_WORDS    = 5;
   // signature assembly from frame words (count, lba low/mid/high)
   localparam int FRM_LBA_WORD = 1;
   localparam int FRM_CNT_WORD = 3;

   typedef enum logic [3:0] {
      PLE_STOPPED, PLE_INIT_RX, PLE_SET_IS, PLE_GEN_INT,
      PLE_SIG_UPD, PLE_POST, PLE_OFFLINE, PLE_START_CLR
   } ple_state_t;
endpackage

// ### hdl/ple_port_fsm.sv
// port link event state machine with wishbone register file
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - device init signal forces init-received state, status loaded ff or 80
// - init-received copies busy and data-request into shadow flags
// - init-received writes 1 into device detection field
// - init-received sets exchanged diagnostic bit
// - connect-change enable chooses set-interrupt-status, else stopped
// - set-interrupt-status sets pending bit; global enable chooses interrupt
// - generate-interrupt raises interrupt then returns to stopped
// - interrupt stays until software clears status bits
// - register frame with start zero loads signature, clears pending flag
// - frame-receive enable chooses posting, else stopped
// - posting writes frame into register-frame area of memory
// - posting loads task file error from frame error field
// - posting loads task file status from frame status field
// - posting refreshes shadow flags then returns to stopped
// - offline state commands phy offline then returns to stopped
// - start bit one-to-zero write enters start-cleared unless controller initialising
// - start-cleared zeroes issue, queued, slot and running flag
// - start-cleared zeroes outstanding dma transfer count
// - reset loads status 7f and sets signature pending
// - frame-receive enable rise with processed frame, diag zero, posts
module ple_port_fsm
   import ple_pkg::*;
#(
   parameter int SLOTS = 32,
   parameter logic COMINIT_ALL_ONES = 1'b1
) (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        link_init_rx,
   input  wire logic        frame_valid,
   input  wire logic [31:0] frame_word0,
   input  wire logic [31:0] frame_word1,
   input  wire logic [31:0] frame_word3,
   input  wire logic        dma_busy,
   input  wire logic        link_start,
   input  wire logic        offline_req,
   output logic             port_irq,
   output logic             mem_wr_en,
   output logic [2:0]       mem_wr_idx,
   output logic [31:0]      mem_wr_data,
   output logic             phy_offline
);
   // ****************************************
   // input synchroniser for the link init pin
   // ****************************************
   logic [1:0] init_sync_q;
   logic       init_prev_q;
   logic       init_evt;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         init_sync_q <= 2'b00;
         init_prev_q <= 1'b0;
      end else if (clk_en) begin
         init_sync_q <= {init_sync_q[0], link_init_rx};
         init_prev_q <= init_sync_q[1];
      end
   end
   // rising edge of the second stage only
   assign init_evt = init_sync_q[1] && !init_prev_q;

   // ****************************************
   // bus handshake
   // ****************************************
   logic wr_stb;

   ple_wb_slave u_wb (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .clk_en    (clk_en),
      .wb_cyc_i  (wb_cyc_i),
      .wb_stb_i  (wb_stb_i),
      .wb_we_i   (wb_we_i),
      .wb_ack_o  (wb_ack_o),
      .wr_strobe (wr_stb),
      .rd_strobe ()
   );
   // reads have no side effects, so the read strobe is left unconnected

   // byte-lane merge used by the control, issue and active registers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   // ****************************************
   // state and register storage
   // ****************************************
   ple_state_t        state_q, state_d;
   logic [7:0]        tfs_q, tfs_d;
   logic [7:0]        tfe_q, tfe_d;
   logic              bsy_q, bsy_d, drq_q, drq_d;
   logic [3:0]        det_q, det_d;
   logic              diag_x_q, diag_x_d;
   logic              ips_q, ips_d;
   logic              irq_q, irq_d;
   logic [31:0]       sig_q, sig_d;
   logic              upd_q, upd_d;
   logic              st_q, st_d, fre_q, fre_d, pce_q, pce_d, gie_q, gie_d, hinit_q, hinit_d;
   logic              cr_q, cr_d;
   logic [4:0]        ccs_q, ccs_d;
   logic [SLOTS-1:0]  ci_q, ci_d, sact_q, sact_d;
   logic [7:0]        xfer_q, xfer_d;
   logic              proc_q, proc_d;
   logic [31:0]       fw0_q, fw0_d, fw1_q, fw1_d, fw3_q, fw3_d;
   logic [2:0]        post_idx_q, post_idx_d;
   logic              offl_q, offl_d;
   logic [31:0]       wr_ctrl;
   logic              wr_ctrl_en;

   assign wr_ctrl_en = wr_stb && wb_adr_i == CTRL_OFS;
   assign wr_ctrl    = merge({16'h0000, 11'h000, hinit_q, gie_q, pce_q, fre_q, st_q},
                             wb_dat_i, wb_sel_i);

   // ****************************************
   // next state and register updates
   // ****************************************
   always_comb begin
      state_d = state_q;  tfs_d = tfs_q;  tfe_d = tfe_q;
      bsy_d = bsy_q;  drq_d = drq_q;  det_d = det_q;
      diag_x_d = diag_x_q;  ips_d = ips_q;  irq_d = irq_q;
      sig_d = sig_q;  upd_d = upd_q;
      st_d = st_q;  fre_d = fre_q;  pce_d = pce_q;  gie_d = gie_q;  hinit_d = hinit_q;
      cr_d = cr_q;  ccs_d = ccs_q;  ci_d = ci_q;  sact_d = sact_q;
      xfer_d = xfer_q;  proc_d = proc_q;
      fw0_d = fw0_q;  fw1_d = fw1_q;  fw3_d = fw3_q;
      post_idx_d = post_idx_q;  offl_d = 1'b0;

      // software writes; status clears lose against a same-cycle set below
      if (wr_ctrl_en) begin
         st_d    = wr_ctrl[CTRL_ST_BIT];
         fre_d   = wr_ctrl[CTRL_FRE_BIT];
         pce_d   = wr_ctrl[CTRL_PCE_BIT];
         gie_d   = wr_ctrl[CTRL_GIE_BIT];
         hinit_d = wr_ctrl[CTRL_HINIT_BIT];
      end
      if (wr_stb && wb_adr_i == STAT_OFS && wb_sel_i[0]) begin
         if (wb_dat_i[STAT_IPS_BIT]) ips_d = 1'b0;
         if (wb_dat_i[STAT_IRQ_BIT]) irq_d = 1'b0;
      end
      if (wr_stb && wb_adr_i == DIAG_OFS && wb_sel_i[0] && wb_dat_i[0]) begin
         diag_x_d = 1'b0;
      end
      if (wr_stb && wb_adr_i == CI_OFS) begin
         ci_d = ci_q | SLOTS'(merge(32'h0, wb_dat_i, wb_sel_i));
      end
      if (wr_stb && wb_adr_i == SACT_OFS) begin
         sact_d = sact_q | SLOTS'(merge(32'h0, wb_dat_i, wb_sel_i));
      end
      if (link_start) begin
         tfs_d = TFS_INIT_VAL;
         upd_d = 1'b1;
      end

      case (state_q)
         PLE_STOPPED: begin
            if (offline_req) begin
               state_d = PLE_OFFLINE;
            end else if (wr_ctrl_en && !fre_q && wr_ctrl[CTRL_FRE_BIT] && proc_q
                         && !diag_x_q) begin
               state_d = PLE_POST;
               post_idx_d = 3'h0;
            end else if (frame_valid && !st_q) begin
               fw0_d = frame_word0;
               fw1_d = frame_word1;
               fw3_d = frame_word3;
               proc_d = 1'b1;
               state_d = PLE_SIG_UPD;
            end
         end
         PLE_INIT_RX: begin
            bsy_d = tfs_q[TFS_BSY_BIT];
            drq_d = tfs_q[TFS_DRQ_BIT];
            det_d = DET_PRESENT;
            diag_x_d = 1'b1;
            state_d = pce_q ? PLE_SET_IS : PLE_STOPPED;
         end
         PLE_SET_IS: begin
            ips_d = 1'b1;
            state_d = gie_q ? PLE_GEN_INT : PLE_STOPPED;
         end
         PLE_GEN_INT: begin
            irq_d = 1'b1;
            state_d = PLE_STOPPED;
         end
         PLE_SIG_UPD: begin
            // signature: count byte, then lba low, mid, high
            sig_d = {fw1_q[23:0], fw3_q[7:0]};
            upd_d = 1'b0;
            post_idx_d = 3'h0;
            state_d = fre_q ? PLE_POST : PLE_STOPPED;
         end
         PLE_POST: begin
            post_idx_d = post_idx_q + 3'h1;
            if (post_idx_q == 3'(FRM_WORDS - 1)) begin
               tfe_d = fw0_q[FRM_ERR_LSB +: 8];
               tfs_d = fw0_q[FRM_STS_LSB +: 8];
               bsy_d = fw0_q[FRM_STS_LSB + TFS_BSY_BIT];
               drq_d = fw0_q[FRM_STS_LSB + TFS_DRQ_BIT];
               state_d = PLE_STOPPED;
            end
         end
         PLE_OFFLINE: begin
            offl_d = 1'b1;
            state_d = PLE_STOPPED;
         end
         PLE_START_CLR: begin
            ci_d = '0;
            sact_d = '0;
            ccs_d = 5'h00;
            cr_d = 1'b0;
            xfer_d = 8'h00;
            state_d = dma_busy ? PLE_START_CLR : PLE_STOPPED;
         end
         default: state_d = PLE_STOPPED;
      endcase

      // asynchronous entries override the table above
      if (wr_ctrl_en && st_q && !wr_ctrl[CTRL_ST_BIT] && !hinit_q) begin
         state_d = PLE_START_CLR;
      end
      if (init_evt) begin
         state_d = PLE_INIT_RX;
         tfs_d = COMINIT_ALL_ONES ? TFS_COMINIT_FF : TFS_COMINIT_80;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= PLE_STOPPED;
         tfs_q <= TFS_INIT_VAL;   tfe_q <= 8'h00;
         bsy_q <= 1'b0;  drq_q <= 1'b0;  det_q <= 4'h0;
         diag_x_q <= 1'b0;  ips_q <= 1'b0;  irq_q <= 1'b0;
         sig_q <= 32'hffff_ffff;  upd_q <= 1'b1;
         st_q <= 1'b0;  fre_q <= 1'b0;  pce_q <= 1'b0;  gie_q <= 1'b0;  hinit_q <= 1'b0;
         cr_q <= 1'b0;  ccs_q <= 5'h00;  ci_q <= '0;  sact_q <= '0;
         xfer_q <= 8'h00;  proc_q <= 1'b0;
         fw0_q <= 32'h0;  fw1_q <= 32'h0;  fw3_q <= 32'h0;
         post_idx_q <= 3'h0;  offl_q <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         tfs_q <= tfs_d;  tfe_q <= tfe_d;
         bsy_q <= bsy_d;  drq_q <= drq_d;  det_q <= det_d;
         diag_x_q <= diag_x_d;  ips_q <= ips_d;  irq_q <= irq_d;
         sig_q <= sig_d;  upd_q <= upd_d;
         st_q <= st_d;  fre_q <= fre_d;  pce_q <= pce_d;  gie_q <= gie_d;  hinit_q <= hinit_d;
         cr_q <= cr_d;  ccs_q <= ccs_d;  ci_q <= ci_d;  sact_q <= sact_d;
         xfer_q <= xfer_d;  proc_q <= proc_d;
         fw0_q <= fw0_d;  fw1_q <= fw1_d;  fw3_q <= fw3_d;
         post_idx_q <= post_idx_d;  offl_q <= offl_d;
      end
   end

   // ****************************************
   // outputs and read mux
   // ****************************************
   assign port_irq    = irq_q;
   assign phy_offline = offl_q;
   assign mem_wr_en   = state_q == PLE_POST;
   assign mem_wr_idx  = post_idx_q;

   // frame words streamed to the register-frame area
   always_comb begin
      case (post_idx_q)
         3'h0:    mem_wr_data = fw0_q;
         3'h1:    mem_wr_data = fw1_q;
         3'h3:    mem_wr_data = fw3_q;
         default: mem_wr_data = 32'h0;
      endcase
   end

   // read data registered so it is stable at ack
   logic [31:0] rdat_q, rdat_d;
   always_comb begin
      case (wb_adr_i)
         CTRL_OFS: rdat_d = {16'h0000, cr_q, 2'b00, ccs_q, 3'b000,
                             hinit_q, gie_q, pce_q, fre_q, st_q};
         STAT_OFS: rdat_d = {16'h0000, 4'(state_q), 3'b000, offl_q, proc_q, upd_q,
                             irq_q, ips_q, det_q};
         TFD_OFS:  rdat_d = {14'h0000, bsy_q, drq_q, tfe_q, tfs_q};
         SIG_OFS:  rdat_d = sig_q;
         CI_OFS:   rdat_d = 32'(ci_q);
         SACT_OFS: rdat_d = 32'(sact_q);
         DIAG_OFS: rdat_d = {24'h000000, xfer_q[6:0], diag_x_q};
         default:  rdat_d = 32'h0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdat_q <= 32'h0;
      end else if (clk_en) begin
         rdat_q <= rdat_d;
      end
   end
   assign wb_dat_o = rdat_q;

   // ****************************************
   // assertions
   // ****************************************
   a_init_enters: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && init_evt |=> state_q == PLE_INIT_RX) else $error("init event not taken");
   a_pce_path: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && state_q == PLE_INIT_RX && !init_evt && !pce_q && !wr_ctrl_en
      |=> state_q == PLE_STOPPED) else $error("init path ignored enable");
   a_irq_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
      port_irq && !wr_stb |=> port_irq) else $error("interrupt dropped");
   a_det_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && state_q == PLE_INIT_RX |=> det_q == DET_PRESENT) else $error("det not set");
   a_clr_slots: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && state_q == PLE_START_CLR |=> ccs_q == 5'h00 && !cr_q) else $error("no clear");
   a_offline_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && state_q == PLE_OFFLINE |=> phy_offline) else $error("offline missed");
   a_sig_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && state_q == PLE_SIG_UPD && !link_start |=> !upd_q) else $error("sig flag kept");
   a_post_len: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && state_q == PLE_POST && post_idx_q == 3'h0 && !init_evt && !wr_ctrl_en
      |=> mem_wr_en) else $error("post cut short");
   a_clr_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && state_q == PLE_START_CLR && dma_busy && !init_evt
      |=> state_q == PLE_START_CLR) else $error("start clear left early");
   a_start_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && link_start && state_q == PLE_STOPPED && !init_evt
      |=> tfs_q == TFS_INIT_VAL && upd_q) else $error("link start load missed");
endmodule
`default_nettype wire

// ### hdl/ple_wb_slave.sv
// classic wishbone slave handshake with one cycle ack
`timescale 1ns/100ps
`default_nettype none
module ple_wb_slave (
   input  wire logic ref_clk,
   input  wire logic reset_n,
   input  wire logic clk_en,
   input  wire logic wb_cyc_i,
   input  wire logic wb_stb_i,
   input  wire logic wb_we_i,
   output logic      wb_ack_o,
   output logic      wr_strobe,
   output logic      rd_strobe
);
   // ****************************************
   // ack generation
   // ****************************************
   logic ack_q;
   logic ack_d;

   // ack one cycle after request, dropped the next cycle
   always_comb begin
      ack_d = wb_cyc_i && wb_stb_i && !ack_q;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
      end else if (clk_en) begin
         ack_q <= ack_d;
      end
   end

   assign wb_ack_o  = ack_q;
   // access takes effect at the ack edge only
   assign wr_strobe = ack_q && wb_cyc_i && wb_stb_i && wb_we_i && clk_en;
   assign rd_strobe = ack_q && wb_cyc_i && wb_stb_i && !wb_we_i && clk_en;
endmodule
`default_nettype wire

// ### test/ple_device_model.sv
// behavioural model of the storage device at the far end of the link
`timescale 1ns/100ps
`default_nettype none
module ple_device_model (
   input  wire logic   ref_clk,
   output logic        link_init_rx,
   output logic        frame_valid,
   output logic [31:0] frame_word0,
   output logic [31:0] frame_word1,
   output logic [31:0] frame_word3
);
   // ****************************************
   // link signalling towards the port
   // ****************************************
   // quiet link at time zero
   initial begin
      link_init_rx = 1'b0;
      frame_valid  = 1'b0;
      frame_word0  = 32'h0;
      frame_word1  = 32'h0;
      frame_word3  = 32'h0;
   end
   // init signal held for hold cycles, long holds mimic a slow drive
   task automatic send_init(input int hold);
      @(posedge ref_clk);
      link_init_rx <= 1'b1;
      repeat (hold) @(posedge ref_clk);
      link_init_rx <= 1'b0;
   endtask
   // one register frame; words inverted after so stale data never matches
   task automatic send_frame(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
      @(posedge ref_clk);
      frame_valid <= 1'b1;
      frame_word0 <= a;
      frame_word1 <= b;
      frame_word3 <= c;
      @(posedge ref_clk);
      frame_valid <= 1'b0;
      frame_word0 <= ~a;
      frame_word1 <= ~b;
      frame_word3 <= ~c;
   endtask
endmodule
`default_nettype wire

// ### test/tb_port_link_event_fsm.sv
// self-checking testbench of the port link event state machine
`timescale 1ns/100ps
`default_nettype none
module tb_port_link_event_fsm;
   import ple_pkg::*;
   logic        ref_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        clk_en = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic        ack;
   logic        init_rx;
   logic        fvalid;
   logic [31:0] fw0;
   logic [31:0] fw1;
   logic [31:0] fw3;
   logic        dma_busy = 1'b0;
   logic        link_start = 1'b0;
   logic        offline_req = 1'b0;
   logic        irq;
   logic        men;
   logic [2:0]  midx;
   logic [31:0] mdata;
   logic        offl;
   logic [31:0] mem_seen [0:7];
   int          mem_cnt = 0;
   int          offl_cnt = 0;
   int          base;
   int          miscompares = 0;
   int          comparisons = 0;
   // ****************************************
   // clock, design and far-side model
   // ****************************************
   always #10 ref_clk = ~ref_clk;
   ple_port_fsm #(.SLOTS(32), .COMINIT_ALL_ONES(1'b1)) dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .link_init_rx(init_rx), .frame_valid(fvalid), .frame_word0(fw0),
      .frame_word1(fw1), .frame_word3(fw3), .dma_busy(dma_busy),
      .link_start(link_start), .offline_req(offline_req), .port_irq(irq),
      .mem_wr_en(men), .mem_wr_idx(midx), .mem_wr_data(mdata), .phy_offline(offl));
   ple_device_model dev (
      .ref_clk(ref_clk), .link_init_rx(init_rx), .frame_valid(fvalid),
      .frame_word0(fw0), .frame_word1(fw1), .frame_word3(fw3));
   // sample outputs mid-cycle, away from the launching edge
   always @(negedge ref_clk) begin
      if (men === 1'b1) begin
         mem_seen[midx] <= mdata;
         mem_cnt <= mem_cnt + 1;
      end
      if (offl === 1'b1) offl_cnt <= offl_cnt + 1;
   end
   // ****************************************
   // bus and checking tasks
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // classic cycle; request held until the rising edge that samples ack high
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      adr <= a;
      we <= w;
      wdat <= d;
      @(posedge ref_clk);
      while (ack !== 1'b1 && n < 50) begin
         @(posedge ref_clk);
         n++;
      end
      if (ack !== 1'b1) miscompares++;
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(a, 1'b1, d, r);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      xfer(a, 1'b0, 32'h0, r);
      chk(r & m, e);
   endtask
   // poll until the state field shows the stopped state again
   task automatic settle();
      logic [31:0] r;
      for (int i = 0; i < 20; i++) begin
         xfer(STAT_OFS, 1'b0, 32'h0, r);
         if (r[15:12] === 4'h0) break;
      end
   endtask
   function automatic logic [31:0] tfd_of(input logic [7:0] s, input logic [7:0] e);
      return {14'h0, s[TFS_BSY_BIT], s[TFS_DRQ_BIT], e, s};
   endfunction
   task automatic post_chk(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
      chk(32'(mem_cnt - base), 32'(FRM_WORDS));
      chk(mem_seen[0], a);
      chk(mem_seen[1], b);
      chk(mem_seen[3], c);
      rdchk(TFD_OFS, 32'h0003_ffff, tfd_of(a[FRM_STS_LSB+:8], a[FRM_ERR_LSB+:8]));
   endtask
   task automatic conclude();
      $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // watchdog, well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      conclude();
   end
   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      rdchk(TFD_OFS, 32'h0000_00ff, {24'h0, TFS_INIT_VAL});
      rdchk(STAT_OFS, 32'h0000_0040, 32'h0000_0040);
      wr(8'h1c, 32'hffff_ffff);
      rdchk(8'h1c, 32'hffff_ffff, 32'h0);
      $display("test reset finished");
      // init signal with both enables, connect enable only, and neither
      for (int k = 0; k < 3; k++) begin
         wr(CTRL_OFS, ((k < 2) ? 32'h4 : 32'h0) | ((k == 0) ? 32'h8 : 32'h0));
         dev.send_init(4 + 4 * k);
         settle();
         rdchk(TFD_OFS, 32'h0003_00ff, tfd_of(TFS_COMINIT_FF, 8'h00));
         rdchk(STAT_OFS, 32'h3f, {26'h0, k == 0, k < 2, DET_PRESENT});
         rdchk(DIAG_OFS, 32'h1, 32'h1);
         @(negedge ref_clk);
         chk({31'h0, irq}, {31'h0, k == 0});
         repeat (30) @(posedge ref_clk);
         chk({31'h0, irq}, {31'h0, k == 0});
         wr(STAT_OFS, 32'h30);
         wr(DIAG_OFS, 32'h1);
         @(negedge ref_clk);
         chk({31'h0, irq}, 32'h0);
      end
      $display("test init finished");
      // frame while receive disabled, then enabling receive posts it
      base = mem_cnt;
      dev.send_frame(32'h5158_4034, 32'h00a5_5ac3, 32'h0000_0096);
      settle();
      rdchk(SIG_OFS, 32'hffff_ffff, 32'ha55a_c396);
      rdchk(STAT_OFS, 32'h0000_0040, 32'h0);
      chk(32'(mem_cnt - base), 32'h0);
      rdchk(TFD_OFS, 32'h0000_00ff, 32'h0000_00ff);
      wr(CTRL_OFS, 32'h2);
      settle();
      post_chk(32'h5158_4034, 32'h00a5_5ac3, 32'h0000_0096);
      base = mem_cnt;
      dev.send_frame(32'h04d0_4034, 32'h0012_3456, 32'h0000_0078);
      settle();
      post_chk(32'h04d0_4034, 32'h0012_3456, 32'h0000_0078);
      $display("test frame finished");
      // link start and offline request; a pulse while frozen must not land
      @(posedge ref_clk);
      clk_en <= 1'b0;
      link_start <= 1'b1;
      @(posedge ref_clk);
      clk_en <= 1'b1;
      link_start <= 1'b0;
      rdchk(TFD_OFS, 32'h0000_00ff, 32'h0000_00d0);
      @(posedge ref_clk);
      link_start <= 1'b1;
      @(posedge ref_clk);
      link_start <= 1'b0;
      rdchk(TFD_OFS, 32'h0000_00ff, {24'h0, TFS_INIT_VAL});
      rdchk(STAT_OFS, 32'h0000_0040, 32'h0000_0040);
      base = offl_cnt;
      offline_req <= 1'b1;
      @(posedge ref_clk);
      offline_req <= 1'b0;
      repeat (10) @(posedge ref_clk);
      chk(32'(offl_cnt - base), 32'h1);
      settle();
      rdchk(STAT_OFS, 32'h0000_f000, 32'h0);
      $display("test offline finished");
      // start bit cleared while the engines are still busy
      wr(CTRL_OFS, 32'h0);
      wr(CI_OFS, 32'h5);
      wr(SACT_OFS, 32'h3);
      wr(CTRL_OFS, 32'h1);
      dma_busy <= 1'b1;
      wr(CTRL_OFS, 32'h0);
      rdchk(STAT_OFS, 32'h0000_f000, 32'h0000_7000);
      rdchk(CI_OFS, 32'hffff_ffff, 32'h0);
      rdchk(SACT_OFS, 32'hffff_ffff, 32'h0);
      rdchk(CTRL_OFS, 32'h0000_9f00, 32'h0);
      rdchk(DIAG_OFS, 32'h0000_00fe, 32'h0);
      repeat (20) @(posedge ref_clk);
      rdchk(STAT_OFS, 32'h0000_f000, 32'h0000_7000);
      dma_busy <= 1'b0;
      settle();
      rdchk(STAT_OFS, 32'h0000_f000, 32'h0);
      // no clean-up while the controller is initialising
      wr(CTRL_OFS, 32'h11);
      wr(CI_OFS, 32'h1);
      wr(CTRL_OFS, 32'h10);
      rdchk(CI_OFS, 32'hffff_ffff, 32'h1);
      rdchk(STAT_OFS, 32'h0000_f000, 32'h0);
      $display("test start clear finished");
      conclude();
   end
endmodule
`default_nettype wire
